//--- temp_format_pkg.sv
// constants for the temperature word and upper alarm threshold register
// assumes a 40 MHz core clock and a register engine outside this block
package temp_format_pkg;
    localparam int WORD_W = 16;
    localparam int SAMPLE_W = 13;
    localparam int CMP_W = 11;
    localparam int HYST_W = 11;
    // weights in micro degrees
    localparam int TEMP_LSB_UDEG = 62500;
    localparam int TEMP_RES_UDEG = 125000;
    localparam int THR_LSB_UDEG = 250000;
    // field positions
    localparam int CRIT_BIT = 15;
    localparam int ABOVE_BIT = 14;
    localparam int BELOW_BIT = 13;
    localparam int SIGN_BIT = 12;
    localparam int DEG128_BIT = 11;
    localparam int CMP_LO_BIT = 2;
    localparam int UNUSED_BIT = 0;
    // masks and reset values
    localparam logic [15:0] THR_WMASK = 16'h1ffc;
    localparam logic [15:0] THR_RESET = 16'h0000;
    localparam logic [15:0] TEMP_RESET = 16'h0000;
endpackage : temp_format_pkg

//--- temp_format_upper_trip.sv
// temperature read-back word with trip status and the upper alarm threshold
// assumes samples, lower/critical words and hysteresis come from other blocks
//
// What this block does
// R1: temperatures are 13-bit two's complement in bits 12:0 of the word with 0.0625 degree per count.
// R2: reported resolution is 0.125 degree and bit 0 of the temperature word is always zero.
// R3: bit 11 weighs 128 degrees and each lower bit halves down to the resolution step.
// R4: the top three bits of the temperature word are trip status from the present temperature and each flag's own current state.
// R5: negative temperatures are two's complement with the sign set, 1e64h being -25.75 degrees.
// R6: the upper threshold is two's complement with 0.25 degree on bit 2, aligned to the temperature.
// R7: threshold bits 15:13 and 1:0 always read zero and ignore writes.
// R8: the alarm comparison always uses the threshold held right now, so new values act at once.
// R9: threshold writes are ignored while I_THR_LOCK is high, so the held value does not change.
// R10: threshold sign bit 12 and magnitude 11:2 are writable and reset to zero.
// R11: bit 15 sets at the critical level and clears below it minus hysteresis; 14 and 13 flag
//      above and below the window, also with hysteresis.
// R12: the upper comparison uses signed temperature bits 12:2 against threshold bits 12:2.
`timescale 1ns/1ps
`default_nettype none
module temp_format_upper_trip
(
    // clock and control
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    // conversion result
    input wire logic I_TEMP_VALID,
    input wire logic [temp_format_pkg::SAMPLE_W-1:0] I_TEMP_SAMPLE,
    // other trip levels
    input wire logic [temp_format_pkg::WORD_W-1:0] I_LOWER_WORD,
    input wire logic [temp_format_pkg::WORD_W-1:0] I_CRIT_WORD,
    input wire logic [temp_format_pkg::HYST_W-1:0] I_HYST,
    // threshold register access
    input wire logic I_THR_WR,
    input wire logic I_THR_LOCK,
    input wire logic [temp_format_pkg::WORD_W-1:0] I_THR_WDATA,
    // read-back
    output logic [temp_format_pkg::WORD_W-1:0] O_TEMP_WORD,
    output logic [temp_format_pkg::WORD_W-1:0] O_THR_WORD
);
    import temp_format_pkg::*;

    logic [WORD_W-1:0] temp_word;
    logic [WORD_W-1:0] upper_alarm_threshold;
    logic signed [CMP_W+1:0] t_cmp;
    logic signed [CMP_W+1:0] up_cmp;
    logic signed [CMP_W+1:0] lo_cmp;
    logic signed [CMP_W+1:0] cr_cmp;
    logic signed [CMP_W+1:0] hys_cmp;
    logic next_crit;
    logic next_above;
    logic next_below;

    // comparison operands, coarse bits only; levels sign-extended, hysteresis zero-extended
    always_comb
    begin
        t_cmp = signed'({{2{temp_word[SIGN_BIT]}}, temp_word[SIGN_BIT:CMP_LO_BIT]}); // R12
        up_cmp = signed'({{2{upper_alarm_threshold[SIGN_BIT]}},
            upper_alarm_threshold[SIGN_BIT:CMP_LO_BIT]}); // R8 R12
        lo_cmp = signed'({{2{I_LOWER_WORD[SIGN_BIT]}}, I_LOWER_WORD[SIGN_BIT:CMP_LO_BIT]});
        cr_cmp = signed'({{2{I_CRIT_WORD[SIGN_BIT]}}, I_CRIT_WORD[SIGN_BIT:CMP_LO_BIT]});
        hys_cmp = signed'({2'b00, I_HYST});
    end

    // trip status with hysteresis
    always_comb
    begin
        if (temp_word[CRIT_BIT])
            next_crit = !(t_cmp < cr_cmp - hys_cmp); // R11
        else
            next_crit = (t_cmp >= cr_cmp); // R11
        if (temp_word[ABOVE_BIT])
            next_above = !(t_cmp < up_cmp - hys_cmp); // R11 R12
        else
            next_above = (t_cmp > up_cmp); // R8 R12
        if (temp_word[BELOW_BIT])
            next_below = (t_cmp < lo_cmp); // R11
        else
            next_below = (t_cmp < lo_cmp - hys_cmp); // R11
    end

    // temperature word: sample in 12:1, bit 0 held low, status on top
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
            temp_word <= TEMP_RESET;
        else if (I_CE)
        begin
            if (I_TEMP_VALID)
                temp_word[SIGN_BIT:UNUSED_BIT+1] <= I_TEMP_SAMPLE[SIGN_BIT:UNUSED_BIT+1]; // R1 R3 R5
            temp_word[UNUSED_BIT] <= 1'b0; // R2
            temp_word[CRIT_BIT] <= next_crit; // R4
            temp_word[ABOVE_BIT] <= next_above; // R4
            temp_word[BELOW_BIT] <= next_below; // R4
        end
    end

    // upper alarm threshold, only sign and magnitude writable
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
            upper_alarm_threshold <= THR_RESET; // R10
        else if (I_CE && I_THR_WR && !I_THR_LOCK)
            upper_alarm_threshold <= I_THR_WDATA & THR_WMASK; // R6 R7 R10
    end

    assign O_TEMP_WORD = temp_word;
    assign O_THR_WORD = upper_alarm_threshold;

    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RESET);

    sequence s_thr_write;
        I_CE && I_THR_WR && !I_THR_LOCK;
    endsequence

    sequence s_above_cause;
        I_CE && !temp_word[ABOVE_BIT] && (t_cmp > up_cmp);
    endsequence

    sequence s_crit_fall;
        I_CE && temp_word[CRIT_BIT] && (t_cmp < cr_cmp - hys_cmp);
    endsequence

    sequence s_below_fall;
        I_CE && temp_word[BELOW_BIT] && !(t_cmp < lo_cmp);
    endsequence

    // register and sample checks
    a_bit0_low: assert property (temp_word[UNUSED_BIT] == 1'b0) // R2
        else $error("temperature bit 0 not zero");

    a_thr_reserved_zero: assert property ((upper_alarm_threshold & ~THR_WMASK) == 16'h0000) // R7
        else $error("threshold reserved bits not zero");

    a_thr_write_takes: assert property (s_thr_write |=>
        upper_alarm_threshold == ($past(I_THR_WDATA) & THR_WMASK)) // R6 R10
        else $error("threshold write lost");

    a_thr_lock_hold: assert property (I_THR_LOCK || !I_THR_WR // R9
        |=> $stable(upper_alarm_threshold))
        else $error("threshold changed without write");

    a_thr_frozen: assert property ( // R10
        !I_CE
        |=> $stable(upper_alarm_threshold))
        else $error("threshold moved while frozen");

    a_temp_load: assert property (I_CE && I_TEMP_VALID |=>
        temp_word[SIGN_BIT:1] == $past(I_TEMP_SAMPLE[SIGN_BIT:1])) // R1 R3 R5
        else $error("sample not loaded");

    a_sample_hold: assert property ( // R1
        I_CE && !I_TEMP_VALID
        |=> $stable(temp_word[SIGN_BIT:1]))
        else $error("sample changed without load");

    a_status_frozen: assert property (!I_CE |=> $stable(temp_word)) // R4
        else $error("status moved while frozen");

    // trip flag checks
    a_above_sets: assert property (s_above_cause |=> temp_word[ABOVE_BIT]) // R8 R12
        else $error("above flag not set");

    a_above_holds: assert property (I_CE && temp_word[ABOVE_BIT] && !(t_cmp < up_cmp - hys_cmp)
        |=> temp_word[ABOVE_BIT]) // R11
        else $error("above flag dropped inside hysteresis");

    a_above_clears: assert property (I_CE && (t_cmp < up_cmp - hys_cmp) && !(t_cmp > up_cmp)
        |=> !temp_word[ABOVE_BIT]) // R11
        else $error("above flag not cleared");

    a_above_stays_low: assert property ( // R8 R11
        I_CE && !temp_word[ABOVE_BIT] && !(t_cmp > up_cmp)
        |=> !temp_word[ABOVE_BIT])
        else $error("above flag set too early");

    a_crit_sets: assert property (I_CE && (t_cmp >= cr_cmp) |=> temp_word[CRIT_BIT]) // R11
        else $error("critical flag not set");

    a_crit_holds: assert property ( // R11
        I_CE && temp_word[CRIT_BIT] && !(t_cmp < cr_cmp - hys_cmp)
        |=> temp_word[CRIT_BIT])
        else $error("critical flag dropped inside hysteresis");

    a_crit_clears: assert property ( // R11
        s_crit_fall
        |=> !temp_word[CRIT_BIT])
        else $error("critical flag not cleared");

    a_crit_stays_low: assert property ( // R11
        I_CE && !temp_word[CRIT_BIT] && (t_cmp < cr_cmp)
        |=> !temp_word[CRIT_BIT])
        else $error("critical flag set too early");

    a_below_sets: assert property (I_CE && (t_cmp < lo_cmp - hys_cmp) |=> temp_word[BELOW_BIT]) // R11
        else $error("below flag not set");

    a_below_holds: assert property ( // R11
        I_CE && temp_word[BELOW_BIT] && (t_cmp < lo_cmp)
        |=> temp_word[BELOW_BIT])
        else $error("below flag dropped inside hysteresis");

    a_below_clears: assert property ( // R11
        s_below_fall
        |=> !temp_word[BELOW_BIT])
        else $error("below flag not cleared");

    a_below_stays_low: assert property ( // R11
        I_CE && !temp_word[BELOW_BIT] && !(t_cmp < lo_cmp - hys_cmp)
        |=> !temp_word[BELOW_BIT])
        else $error("below flag set too early");
endmodule : temp_format_upper_trip
`default_nettype wire

//--- temp_host_model.sv
// host model writing the upper threshold register
// assumes the block takes a write on the rising core clock
`timescale 1ns/1ps
`default_nettype none
module temp_host_model
(
    // clock
    input wire logic i_clk,
    // threshold write
    output logic o_wr,
    output logic o_lock,
    output logic [15:0] o_wdata
);
    initial
    begin
        o_wr = 1'b0;
        o_lock = 1'b0;
        o_wdata = 16'h0000;
    end
    // lock high makes the block ignore the write, so the threshold value does not change
    task automatic wr(input logic [15:0] d, input logic lk);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_wdata <= d;
        o_lock <= lk;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask : wr
endmodule : temp_host_model
`default_nettype wire

//--- temp_format_upper_trip_tb_top.sv
// bench for the temperature word and upper threshold
// assumes the host model drives the write port
`timescale 1ns/1ps
`default_nettype none
module temp_format_upper_trip_tb_top;
    import temp_format_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic vld = 1'b0;
    logic [12:0] smp = 13'h0000;
    logic wr;
    logic lock;
    logic [15:0] wdata;
    logic [15:0] tw;
    logic [15:0] thr;
    logic [15:0] e;
    logic ce = 1'b1;
    logic [10:0] hys = 11'h000;
    logic [15:0] lower = 16'h1000;
    logic [15:0] crit = 16'h0ffc;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [12:0] tbl [5] = '{13'h0190, 13'h1e64, 13'h1ffe, 13'h07d0, 13'h0003};
    temp_host_model temp_host_model_inst (.i_clk(clk), .o_wr(wr), .o_lock(lock), .o_wdata(wdata));
    temp_format_upper_trip temp_format_upper_trip_inst (.I_CORE_CLK(clk), .I_RESET(rst),
        .I_CE(ce), .I_TEMP_VALID(vld), .I_TEMP_SAMPLE(smp), .I_LOWER_WORD(lower),
        .I_CRIT_WORD(crit), .I_HYST(hys), .I_THR_WR(wr), .I_THR_LOCK(lock),
        .I_THR_WDATA(wdata), .O_TEMP_WORD(tw), .O_THR_WORD(thr));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    function automatic logic [15:0] exp_thr(input logic [15:0] d);
        return d & THR_WMASK;
    endfunction : exp_thr
    task automatic w(input logic [15:0] d, input logic lk);
        temp_host_model_inst.wr(d, lk);
        if (!lk)
            e = exp_thr(d);
        @(posedge clk);
        #1 chk(thr === e, "threshold word");
    endtask : w
    task automatic ld(input logic [12:0] s, input logic [2:0] st);
        @(posedge clk);
        vld <= 1'b1;
        smp <= s;
        @(posedge clk);
        vld <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(tw[12:0] === {s[12:1], 1'b0} && tw[15:13] === st, "temp word");
    endtask : ld
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            test_done();
        end
    end
    initial
    begin
        void'($urandom(92897));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk(thr === THR_RESET && tw === TEMP_RESET, "reset");
        e = THR_RESET;
        w(16'hffff, 1'b0);
        for (int i = 0; i < 8; i++)
            w(16'($urandom), 1'($urandom));
        w(16'h0ffc, 1'b0);
        foreach (tbl[i])
            ld(tbl[i], 3'b000);
        w(16'h0190, 1'b0);
        ld(13'h018c, 3'b000);
        ld(13'h0192, 3'b000);
        ld(13'h0194, 3'b010);
        w(16'h0198, 1'b0);
        ld(13'h0194, 3'b000);
        // enable low: write ignored, word frozen
        @(posedge clk);
        ce <= 1'b0;
        temp_host_model_inst.wr(16'h0040, 1'b0);
        @(posedge clk);
        #1 chk(thr === e && tw === 16'h0194, "frozen");
        @(posedge clk);
        ce <= 1'b1;
        hys <= 11'd6;
        ld(13'h0198, 3'b000);
        ld(13'h019c, 3'b010);
        ld(13'h0190, 3'b010);
        ld(13'h017c, 3'b000);
        lower <= 16'h0100;
        ld(13'h00e0, 3'b001);
        ld(13'h00ec, 3'b001);
        ld(13'h0100, 3'b000);
        crit <= 16'h0200;
        ld(13'h0200, 3'b110);
        ld(13'h01f0, 3'b110);
        ld(13'h01e0, 3'b010);
        test_done();
    end
endmodule : temp_format_upper_trip_tb_top
`default_nettype wire
